/* rtl/dmaec_axil_slave.sv */
// AXI4-Lite slave front end that turns bus beats into register strobes.
`timescale 1ns/1ps
`default_nettype none
module dmaec_axil_slave
   import dmaec_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [DATA_W-1:0]      rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic                   wr_en,
   output logic [ADDR_W-1:0]      wr_addr,
   output logic [DATA_W-1:0]      wr_data,
   output logic [3:0]             wr_strb,
   input  wire logic              wr_err,
   input  wire logic [DATA_W-1:0] rd_data,
   input  wire logic              rd_err
);
   logic aw_have_q;
   logic w_have_q;

   // Each channel is taken once and held until the response is accepted.
   assign awready = ce && !aw_have_q && !bvalid;
   assign wready = ce && !w_have_q && !bvalid;
   assign arready = ce && !rvalid;
   assign wr_en = ce && aw_have_q && w_have_q && !bvalid;

   // Write address and data capture, in either order.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
         wr_strb <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end
      else if (ce)
      begin
         if (awvalid && awready)
         begin
            aw_have_q <= 1'b1;
            wr_addr <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_have_q <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (wr_en)
         begin
            bvalid <= 1'b1;
            bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // Read data is sampled at the address beat; reads have no side effects.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end
      else if (ce)
      begin
         if (arvalid && arready)
         begin
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
         end
         else if (rvalid && rready)
            rvalid <= 1'b0;
      end
   end
endmodule // dmaec_axil_slave
`default_nettype wire

/* rtl/dmaec_irq_sel.sv */
// Interrupt number selector with occurrence edge detect and enable gate.
`timescale 1ns/1ps
`default_nettype none
module dmaec_irq_sel
   import dmaec_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic         ce,
   input  wire logic [255:0] irq_lines,
   input  wire logic [7:0]   select,
   input  wire logic         enable,
   output logic              occur,
   output logic              hit
);
   logic prev_q;
   logic line_now;

   // The selected line rising is one occurrence of that interrupt.
   assign line_now = irq_lines[select];
   assign occur = ce && line_now && !prev_q;
   assign hit = occur && enable;

   // Previous level of the selected line.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         prev_q <= 1'b0;
      else if (ce)
         prev_q <= line_now;
   end
endmodule // dmaec_irq_sel
`default_nettype wire

/* rtl/dmaec_top.sv */
// DMA channel event control, pointer readback and register file.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dmaec_top
   import dmaec_pkg::*;
(
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   input  wire logic                        ce,
   input  wire logic [dmaec_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [dmaec_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic [1:0]                       s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [dmaec_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic [dmaec_pkg::DATA_W-1:0]      s_axi_rdata,
   output logic [1:0]                       s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready,
   input  wire logic [255:0]                irq_lines,
   input  wire logic                        pattern_match,
   input  wire logic                        src_step,
   input  wire logic                        dst_step,
   input  wire logic                        xfer_done,
   output logic                             xfer_start,
   output logic                             xfer_abort,
   output logic                             xfer_busy,
   output logic                             channel_on,
   output logic                             irq
);
   // ***************************************************************
   // Declarations
   // ***************************************************************
   dmaec_xfer_state_t state_q;
   logic [31:0]       econ_q;
   logic [1:0]        ctrl_q;
   logic [IRQ_W-1:0]  istat_q;
   logic [IRQ_W-1:0]  ien_q;
   logic [15:0]       src_ptr_q;
   logic [15:0]       dst_ptr_q;
   logic              wr_en;
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [3:0]        wr_strb;
   logic              wr_err;
   logic [DATA_W-1:0] rd_data;
   logic              rd_err;
   logic [31:0]       wr_mask;
   logic [31:0]       wr_eff;
   logic [1:0]        wr_alias;
   logic [ADDR_W-1:0] wr_group;
   logic [ADDR_W-1:0] rd_group;
   logic              wr_econ;
   logic              wr_ctrl;
   logic              force_hit;
   logic              abort_strobe;
   logic              start_occur;
   logic              start_hit;
   logic              abort_occur;
   logic              abort_irq_hit;
   logic              pattern_abort;
   logic              abort_any;
   logic              start_req;
   logic              start_go;
   logic [IRQ_W-1:0]  irq_events;

   // ***************************************************************
   // Bus front end
   // ***************************************************************
   dmaec_axil_slave u_axil (
      .clk     (clk),
      .reset_n (reset_n),
      .ce      (ce),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_err  (wr_err),
      .rd_data (rd_data),
      .rd_err  (rd_err)
   );

   // Function that applies a base, clear, set or invert write to a value.
   function automatic logic [31:0] apply_alias(input logic [31:0] old,
                                               input logic [31:0] eff,
                                               input logic [31:0] mask,
                                               input logic [1:0]  alias_sel);
      logic [31:0] res;
      res = old;
      unique case (alias_sel)
         ALIAS_BASE: res = (old & ~mask) | eff;
         ALIAS_CLR:  res = old & ~eff;
         ALIAS_SET:  res = old | eff;
         ALIAS_INV:  res = old ^ eff;
      endcase
      return res;
   endfunction

   // Write decode: group base plus alias selected by address bits 3:2.
   assign wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
   assign wr_eff = wr_data & wr_mask;
   assign wr_alias = wr_addr[3:2];
   assign wr_group = wr_addr & GROUP_MASK;
   assign rd_group = s_axi_araddr & GROUP_MASK;
   assign wr_econ = wr_en && (wr_group == OFF_ECON);
   assign wr_ctrl = wr_en && (wr_group == OFF_CTRL);

   // Unmapped groups, misaligned addresses and aliases of the interrupt status, enable and clear registers error.
   always_comb
   begin
      wr_err = 1'b0;
      if (wr_addr[1:0] != 2'h0)
         wr_err = 1'b1;
      else if ((wr_group == OFF_ISTAT) || (wr_group == OFF_IEN) || (wr_group == OFF_ICLR))
         wr_err = (wr_alias != ALIAS_BASE);
      else if ((wr_group != OFF_ECON) && (wr_group != OFF_SPTR) &&
               (wr_group != OFF_DPTR) && (wr_group != OFF_CTRL))
         wr_err = 1'b1;
   end

   // Read mux; strobes, unimplemented bits and pointer upper halves read zero.
   always_comb
   begin
      rd_data = '0;
      rd_err = (s_axi_araddr[1:0] != 2'h0);
      unique case (rd_group)
         OFF_ECON:  rd_data = econ_q & ECON_WMASK;
         OFF_SPTR:  rd_data = {16'h0000, src_ptr_q};
         OFF_DPTR:  rd_data = {16'h0000, dst_ptr_q};
         OFF_CTRL:  rd_data = {30'h0000_0000, ctrl_q};
         OFF_ISTAT: rd_data = {29'h0000_0000, istat_q};
         OFF_IEN:   rd_data = {29'h0000_0000, ien_q};
         OFF_ICLR:  rd_data = '0;
         default:   rd_err = 1'b1;
      endcase
   end

   // ***************************************************************
   // Event sources
   // ***************************************************************
   dmaec_irq_sel u_start_sel (
      .clk       (clk),
      .reset_n   (reset_n),
      .ce        (ce),
      .irq_lines (irq_lines),
      .select    (econ_q[ECON_SIRQ_LSB +: 8]),
      .enable    (econ_q[ECON_START_REQUEST_ENABLE]),
      .occur     (start_occur),
      .hit       (start_hit)
   );

   dmaec_irq_sel u_abort_sel (
      .clk       (clk),
      .reset_n   (reset_n),
      .ce        (ce),
      .irq_lines (irq_lines),
      .select    (econ_q[ECON_AIRQ_LSB +: 8]),
      .enable    (econ_q[ECON_ABORT_REQUEST_ENABLE]),
      .occur     (abort_occur),
      .hit       (abort_irq_hit)
   );

   // Strobe bits act on base, set and invert writes of a one; clear does nothing.
   assign force_hit = wr_econ && (wr_alias != ALIAS_CLR) && wr_eff[ECON_FORCE];
   assign abort_strobe = wr_econ && (wr_alias != ALIAS_CLR) && wr_eff[ECON_ABORT];
   assign pattern_abort = ce && pattern_match && econ_q[ECON_PATTERN_ABORT_ENABLE];
   assign abort_any = abort_irq_hit || abort_strobe || pattern_abort;
   assign start_req = (start_hit || force_hit) && ctrl_q[CTRL_CHON];
   assign start_go = start_req && !abort_any;

   // ***************************************************************
   // Event control and channel control registers
   // ***************************************************************
   // Event control keeps only its writable bits; strobes never store.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         econ_q <= ECON_RESET;
      else if (ce && wr_econ)
         econ_q <= apply_alias(econ_q, wr_eff, wr_mask, wr_alias) & ECON_WMASK;
   end

   // Channel on and pattern mode; a pattern abort clears channel on.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         ctrl_q <= CTRL_RESET;
      else if (ce)
      begin
         if (wr_ctrl)
            ctrl_q <= 2'(apply_alias({30'h0000_0000, ctrl_q}, wr_eff, wr_mask, wr_alias));
         if (pattern_abort)
            ctrl_q[CTRL_CHON] <= 1'b0;
      end
   end

   // ***************************************************************
   // Transfer sequencing
   // ***************************************************************
   // Idle until a start; any abort or the data path's done returns to idle.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         state_q <= XFER_IDLE;
      else if (ce)
      begin
         unique case (state_q)
            XFER_IDLE:
               if (start_go)
                  state_q <= XFER_BUSY;
            XFER_BUSY:
               if (abort_any || xfer_done)
                  state_q <= XFER_IDLE;
         endcase
      end
   end

   // One-cycle pulses towards the data path for each start, and for each abort taken while busy.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         xfer_start <= 1'b0;
         xfer_abort <= 1'b0;
      end
      else if (ce)
      begin
         xfer_start <= start_go;
         xfer_abort <= abort_any && (state_q == XFER_BUSY);
      end
   end

   assign xfer_busy = (state_q == XFER_BUSY);
   assign channel_on = ctrl_q[CTRL_CHON];

   // ***************************************************************
   // Byte pointers
   // ***************************************************************
   // Source pointer: zero on a fresh transfer or a pattern in pattern mode.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         src_ptr_q <= PTR_RESET;
      else if (ce)
      begin
         if (pattern_match && ctrl_q[CTRL_PATMODE])
            src_ptr_q <= PTR_RESET;
         else if (start_go && (state_q == XFER_IDLE))
            src_ptr_q <= PTR_RESET;
         else if (src_step && (state_q == XFER_BUSY))
            src_ptr_q <= src_ptr_q + 16'h0001;
      end
   end

   // Destination pointer: byte index that wraps after the last byte.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         dst_ptr_q <= PTR_RESET;
      else if (ce)
      begin
         if (start_go && (state_q == XFER_IDLE))
            dst_ptr_q <= PTR_RESET;
         else if (dst_step && (state_q == XFER_BUSY))
            dst_ptr_q <= dst_ptr_q + 16'h0001;
      end
   end

   // ***************************************************************
   // Interrupt status, enable and clear
   // ***************************************************************
   assign irq_events[IRQ_ABORT] = abort_any;
   assign irq_events[IRQ_START] = start_go;
   assign irq_events[IRQ_DONE] = xfer_done && (state_q == XFER_BUSY) && !abort_any;

   // Sticky status; a new event wins over a clear in the same cycle.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         istat_q <= IRQ_RESET;
      else if (ce)
      begin
         if (wr_en && (wr_group == OFF_ICLR) && (wr_alias == ALIAS_BASE))
            istat_q <= (istat_q & ~wr_eff[IRQ_W-1:0]) | irq_events;
         else
            istat_q <= istat_q | irq_events;
      end
   end

   // Interrupt enable register.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         ien_q <= IRQ_RESET;
      else if (ce && wr_en && (wr_group == OFF_IEN) && (wr_alias == ALIAS_BASE))
         ien_q <= (ien_q & ~wr_mask[IRQ_W-1:0]) | wr_eff[IRQ_W-1:0];
   end

   assign irq = |(istat_q & ien_q);

   // ***************************************************************
   // Assertions
   // ***************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   force_start_a: assert property (ce && force_hit && ctrl_q[CTRL_CHON] && !abort_any
      |=> xfer_start && xfer_busy) else $error("Forced start did not begin a transfer.");
   start_irq_a: assert property (ce && start_hit && ctrl_q[CTRL_CHON] && !abort_any
      |=> xfer_start ##1 !xfer_start || start_go) else $error("Start interrupt lost.");
   start_ignore_a: assert property (ce && start_occur && !econ_q[ECON_START_REQUEST_ENABLE] && !force_hit
      |=> !xfer_start) else $error("Disabled start interrupt started a transfer.");
   abort_irq_a: assert property (ce && xfer_busy && abort_irq_hit
      |=> !xfer_busy && xfer_abort && istat_q[IRQ_ABORT]) else $error("Abort interrupt ignored.");
   abort_ignore_a: assert property (ce && xfer_busy && abort_occur && !econ_q[ECON_ABORT_REQUEST_ENABLE]
      && !abort_strobe && !pattern_abort && !xfer_done |=> xfer_busy && !xfer_abort)
      else $error("Disabled abort interrupt ended a transfer.");
   abort_strobe_a: assert property (ce && xfer_busy && abort_strobe
      |=> !xfer_busy && xfer_abort) else $error("Abort strobe did not abort.");
   pattern_abort_a: assert property (ce && pattern_match && econ_q[ECON_PATTERN_ABORT_ENABLE]
      |=> !channel_on) else $error("Pattern abort kept channel on.");
   pattern_ptr_a: assert property (ce && pattern_match && ctrl_q[CTRL_PATMODE]
      |=> src_ptr_q == 16'h0000) else $error("Pattern did not reset source pointer.");
   abort_wins_a: assert property (ce && start_req && abort_any
      |=> !xfer_start) else $error("Start taken beside an abort.");
   econ_read_a: assert property (rd_group == OFF_ECON
      |-> rd_data[7:6] == 2'h0 && rd_data[2:0] == 3'h0) else $error("Strobe bits read back.");
   ptr_upper_a: assert property ((rd_group == OFF_SPTR) || (rd_group == OFF_DPTR)
      |-> rd_data[31:16] == 16'h0000) else $error("Pointer upper half not zero.");

   start_seen_c: cover property (ce && start_hit && ctrl_q[CTRL_CHON] ##1 xfer_busy);
   abort_seen_c: cover property (xfer_busy ##1 xfer_abort);
   irq_seen_c: cover property (irq ##[1:20] !irq);
endmodule // dmaec_top
`default_nettype wire

/* shared/dmaec_pkg.sv */
// Constants, register map and types shared by the channel event control block.
`default_nettype none
package dmaec_pkg;
   // ***************************************************************
   // Bus widths and register map
   // ***************************************************************
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam logic [7:0] OFF_ECON = 8'h00;
   localparam logic [7:0] OFF_SPTR = 8'h10;
   localparam logic [7:0] OFF_DPTR = 8'h20;
   localparam logic [7:0] OFF_CTRL = 8'h30;
   localparam logic [7:0] OFF_ISTAT = 8'h40;
   localparam logic [7:0] OFF_IEN = 8'h50;
   localparam logic [7:0] OFF_ICLR = 8'h60;
   localparam logic [1:0] ALIAS_BASE = 2'h0;
   localparam logic [1:0] ALIAS_CLR = 2'h1;
   localparam logic [1:0] ALIAS_SET = 2'h2;
   localparam logic [1:0] ALIAS_INV = 2'h3;
   localparam logic [7:0] GROUP_MASK = 8'hF0;
   // ***************************************************************
   // Event control and channel control fields and reset values
   // ***************************************************************
   localparam int unsigned ECON_AIRQ_LSB = 16;
   localparam int unsigned ECON_SIRQ_LSB = 8;
   localparam int unsigned ECON_FORCE = 7;
   localparam int unsigned ECON_ABORT = 6;
   localparam int unsigned ECON_PATTERN_ABORT_ENABLE = 5;
   localparam int unsigned ECON_START_REQUEST_ENABLE = 4;
   localparam int unsigned ECON_ABORT_REQUEST_ENABLE = 3;
   localparam logic [31:0] ECON_WMASK = 32'h00FF_FF38;
   localparam logic [31:0] ECON_RESET = 32'h00FF_FF00;
   localparam logic [15:0] PTR_RESET = 16'h0000;
   localparam int unsigned CTRL_CHON = 0;
   localparam int unsigned CTRL_PATMODE = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // ***************************************************************
   // Interrupt status bits and bus responses
   // ***************************************************************
   localparam int unsigned IRQ_W = 3;
   localparam int unsigned IRQ_ABORT = 0;
   localparam int unsigned IRQ_START = 1;
   localparam int unsigned IRQ_DONE = 2;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Transfer sequencing state.
   typedef enum logic [0:0] {
      XFER_IDLE = 1'b0,
      XFER_BUSY = 1'b1
   } dmaec_xfer_state_t;
endpackage : dmaec_pkg
`default_nettype wire

/* verification/dma_channel_event_control_tb_top.sv */
// Self-checking bench for the channel event control block.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_event_control_tb_top;
   import dmaec_pkg::*;
   logic          clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic          s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic          s_axi_rready, pattern_match, src_step, dst_step, xfer_start, xfer_abort;
   logic          channel_on, irq, xfer_busy;
   logic [7:0]    s_axi_awaddr, s_axi_araddr, s_sel, a_sel;
   logic [31:0]   s_axi_wdata, s_axi_rdata, v;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   logic [255:0]  irq_lines;
   int            n_errors = 0, n_compared = 0, e_st = 0, e_ab = 0, n_st = 0, n_ab = 0, n;
   int            e_bz = 0;
   dmaec_top dmaec_top_inst (.clk, .reset_n, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_lines,
      .pattern_match, .src_step, .dst_step, .xfer_done(1'b0), .xfer_start, .xfer_abort,
      .xfer_busy, .channel_on, .irq);
   dmaec_partner dmaec_partner_inst (.clk, .irq_lines, .src_step, .dst_step, .pattern_match);
   // Free-running clock and pulse counters.
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      n_st <= n_st + xfer_start;
      n_ab <= n_ab + xfer_abort;
   end
   task automatic finish_test();
      if (n_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bus master: each channel is dropped at the edge that takes it.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do
      begin
         @(posedge clk);
         s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
         s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", r, s_axi_bresp);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do
      begin
         @(posedge clk);
         s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk("rdata", e, s_axi_rdata);
      chk("rresp", r, s_axi_rresp);
   endtask
   // Let events settle, then compare start and abort pulse counts with the model.
   task automatic evt(input int ds, input int da);
      repeat (4) @(posedge clk);
      e_st += ds;
      e_ab += da;
      if (ds != 0 || da != 0)
         e_bz = ds;
      chk("starts", e_st, n_st);
      chk("aborts", e_ab, n_ab);
      chk("busy", e_bz, xfer_busy);
   endtask
   // Main sequence.
   initial
   begin
      {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      v = $urandom(32'hF707);
      s_sel = $urandom;
      a_sel = s_sel ^ 8'h5A;
      n = $urandom_range(8, 1);
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      rd(OFF_ECON, ECON_RESET, RESP_OKAY);
      rd(OFF_SPTR, 32'h0, RESP_OKAY);
      rd(OFF_DPTR, 32'h0, RESP_OKAY);
      v = {8'hFF, a_sel, s_sel, 8'hFF};
      wr(OFF_ECON, v, RESP_OKAY);
      rd(OFF_ECON, v & ECON_WMASK, RESP_OKAY);
      wr(OFF_CTRL + 8'h8, 32'h1, RESP_OKAY);
      dmaec_partner_inst.fire(s_sel, 8'h0, 1'b0);
      evt(1, 0);
      dmaec_partner_inst.pulse(n, 3'h3);
      rd(OFF_SPTR + 8'h4, n, RESP_OKAY);
      rd(OFF_DPTR, n, RESP_OKAY);
      dmaec_partner_inst.fire(a_sel, 8'h0, 1'b0);
      evt(0, 1);
      wr(OFF_ECON + 8'h4, 32'h18, RESP_OKAY);
      wr(OFF_ECON + 8'h8, 32'h80, RESP_OKAY);
      evt(1, 0);
      dmaec_partner_inst.fire(s_sel, a_sel, 1'b1);
      evt(0, 0);
      wr(OFF_ECON + 8'hC, 32'h40, RESP_OKAY);
      evt(0, 1);
      wr(OFF_ECON + 8'h8, 32'h18, RESP_OKAY);
      dmaec_partner_inst.fire(s_sel, a_sel, 1'b1);
      evt(0, 0);
      wr(OFF_CTRL + 8'h8, 32'h2, RESP_OKAY);
      wr(OFF_ECON + 8'h8, 32'h80, RESP_OKAY);
      evt(1, 0);
      dmaec_partner_inst.pulse(n, 3'h1);
      dmaec_partner_inst.pulse(1, 3'h4);
      evt(0, 1);
      chk("channel_on", 32'h0, channel_on);
      rd(OFF_SPTR, 32'h0, RESP_OKAY);
      wr(OFF_IEN, 32'h1, RESP_OKAY);
      chk("irq", 32'h1, irq);
      wr(OFF_ICLR, 32'h1, RESP_OKAY);
      chk("irq", 32'h0, irq);
      rd(OFF_ISTAT, 32'h2, RESP_OKAY);
      wr(8'h70, $urandom, RESP_SLVERR);
      rd(8'h70, 32'h0, RESP_SLVERR);
      finish_test();
   end
   // Watchdog cuts a hang short.
   initial
   begin
      repeat (5000) @(posedge clk);
      n_errors++;
      finish_test();
   end
endmodule // dma_channel_event_control_tb_top
`default_nettype wire

/* verification/dmaec_partner.sv */
// Far side model: interrupt sources and data path pulses.
`timescale 1ns/1ps
`default_nettype none
module dmaec_partner (
   input  wire logic         clk,
   output logic [255:0]      irq_lines,
   output logic              src_step,
   output logic              dst_step,
   output logic              pattern_match
);
   // Lines idle low; an occurrence is a single high cycle on one line.
   initial
   begin
      irq_lines = '0;
      {pattern_match, dst_step, src_step} = 3'h0;
   end
   // Raise one or two request lines together for one cycle.
   task automatic fire(input logic [7:0] a, input logic [7:0] b, input logic two);
      @(posedge clk);
      irq_lines[a] <= 1'b1;
      if (two)
         irq_lines[b] <= 1'b1;
      @(posedge clk);
      irq_lines <= '0;
   endtask
   // Hold the chosen pulses {pattern, dst, src} high for n cycles.
   task automatic pulse(input int n, input logic [2:0] w);
      repeat (n) @(posedge clk) {pattern_match, dst_step, src_step} <= w;
      @(posedge clk);
      {pattern_match, dst_step, src_step} <= 3'h0;
   endtask
endmodule // dmaec_partner
`default_nettype wire
